// file: rtl/civ_core.v
`timescale 1ns/1ns
`include "civ_defs.vh"
module civ_core (
	// clock and reset
	input  wire        clock,
	input  wire        rst_n,
	// interrupt request lines (asynchronous)
	input  wire [15:0] irq_lines,
	// control register move port
	input  wire        mv_wr,
	input  wire [2:0]  mv_sel,
	input  wire [31:0] mv_wdata,
	output reg  [31:0] mv_rdata,
	// pipeline events
	input  wire        take_maskable,
	input  wire        take_nmi,
	input  wire [31:0] return_pc,
	input  wire        ret_maskable,
	input  wire        ret_nmi,
	// pipeline status
	output wire        maskable_req,
	output wire [4:0]  req_number,
	output wire [31:0] vector_addr,
	output wire [31:0] nonmaskable_return_pointer,
	output wire [31:0] maskable_return_pointer
);
	reg  [15:0] sync1_q;
	reg  [15:0] sync2_q;
	reg  [15:0] prev_q;
	reg  [31:0] control_status_reg_q;
	reg  [31:0] control_status_reg_d;
	reg  [15:0] enable_mask_reg_q;
	reg  [15:0] enable_mask_reg_d;
	reg  [15:0] pending_flag_reg_q;
	wire [15:0] pending_flag_reg_d;
	reg  [21:0] vector_table_base_q;
	reg  [31:0] nm_ret_q;
	reg  [31:0] mk_ret_q;
	wire [15:0] rise;
	wire [15:0] cand;
	wire [4:0]  top_candidate_number;
	wire [31:0] vector_table_pointer;
	wire [15:0] set_w;
	wire [15:0] clr_w;
	wire [15:0] take_hot;
	wire [15:0] nmi_hot;
	wire [15:0] kill_w;
	wire        gen_after_sw;
	wire        ctrl_wr;
	wire        mask_wr;
	wire        top_is_nmi;
	genvar      g;

	// lanes that can hold a pending flag at all
	localparam [15:0] LANE_OK = `CIV_EDGE_LANES;

	// two-flop synchroniser, edge detect on second stage only
	always @(posedge clock) begin
		if (!rst_n) begin
			sync1_q <= 16'h0000;
			sync2_q <= 16'h0000;
			prev_q  <= 16'h0000;
		end else begin
			sync1_q <= irq_lines;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end
	assign rise = sync2_q & ~prev_q;

	// decoded write strobes for the move port
	assign ctrl_wr = mv_wr && (mv_sel == `CIV_SEL_CTRL);
	assign mask_wr = mv_wr && (mv_sel == `CIV_SEL_MASK);

	// candidate set and priority pick, combinational each cycle
	assign cand = pending_flag_reg_q & enable_mask_reg_q;
	civ_prio_enc u_enc (
		.cand (cand),
		.num  (top_candidate_number)
	);
	// base on top, winner in the number field, packet offset zero
	assign vector_table_pointer = {vector_table_base_q,
		top_candidate_number, 5'h00};

	// a pending enabled nmi outranks every maskable candidate
	assign top_is_nmi = cand[`CIV_NMI_BIT];

	// maskable request: maskable winner, global enable, nmi gate
	assign maskable_req = (|(cand & `CIV_MASKABLE))
		& ~top_is_nmi
		& control_status_reg_q[`CIV_GEN_BIT]
		& enable_mask_reg_q[`CIV_NMI_BIT];
	assign req_number  = top_candidate_number;
	assign vector_addr = vector_table_pointer;
	assign nonmaskable_return_pointer = nm_ret_q;
	assign maskable_return_pointer    = mk_ret_q;

	// software flag set/clear strobes, maskable lanes only
	assign set_w = (mv_wr && mv_sel == `CIV_SEL_FSET) ?
		(mv_wdata[15:0] & `CIV_MASKABLE) : 16'h0000;
	assign clr_w = (mv_wr && mv_sel == `CIV_SEL_FCLR) ?
		(mv_wdata[15:0] & `CIV_MASKABLE) : 16'h0000;

	// software view of the global enable this cycle
	assign gen_after_sw = ctrl_wr ?
		mv_wdata[`CIV_GEN_BIT] : control_status_reg_q[`CIV_GEN_BIT];

	// control/status next value
	always @* begin
		control_status_reg_d = control_status_reg_q;
		if (ctrl_wr) begin
			control_status_reg_d = mv_wdata;
		end
		if (take_maskable) begin
			// a coinciding software clear lands before the copy
			control_status_reg_d[`CIV_SAVED_BIT] =
				gen_after_sw;
			control_status_reg_d[`CIV_GEN_BIT] = 1'h0;
		end else if (ret_maskable) begin
			control_status_reg_d[`CIV_GEN_BIT] =
				control_status_reg_q[`CIV_SAVED_BIT];
		end
	end

	// enable mask next value; reset lane fixed, nmi gate set-only from the move port, cleared by take_nmi
	always @* begin
		enable_mask_reg_d = enable_mask_reg_q;
		if (mask_wr) begin
			enable_mask_reg_d[15:2] = mv_wdata[15:2];
			// a written zero leaves the gate alone
			enable_mask_reg_d[`CIV_NMI_BIT] =
				enable_mask_reg_q[`CIV_NMI_BIT] | mv_wdata[`CIV_NMI_BIT];
		end
		if (ret_nmi) begin
			enable_mask_reg_d[`CIV_NMI_BIT] = 1'h1;
		end
		if (take_nmi) begin
			enable_mask_reg_d[`CIV_NMI_BIT] = 1'h0;
		end
		enable_mask_reg_d[`CIV_RSV_HI:`CIV_RSV_LO] = 2'h0;
		enable_mask_reg_d[`CIV_RST_BIT] = 1'h1;
	end

	// one-hot clears for the interrupt being taken this cycle
	assign take_hot = take_maskable ?
		(16'h0001 << top_candidate_number[3:0]) : 16'h0000;
	assign nmi_hot  = take_nmi ?
		(16'h0001 << `CIV_NMI_BIT) : 16'h0000;
	assign kill_w   = clr_w | take_hot | nmi_hot;

	// pending flags, one lane per interrupt; an incoming edge or a
	// software set beats any clear in the same cycle, so none is lost
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_flag
			assign pending_flag_reg_d[g] = LANE_OK[g]
				& ((pending_flag_reg_q[g] & ~kill_w[g])
				| set_w[g] | rise[g]);
		end
	endgenerate

	// register state
	always @(posedge clock) begin
		if (!rst_n) begin
			control_status_reg_q <= `CIV_CTRL_RST;
			enable_mask_reg_q    <= `CIV_MASK_RST;
			pending_flag_reg_q   <= `CIV_PEND_RST;
			vector_table_base_q  <= `CIV_BASE_RST;
			nm_ret_q             <= `CIV_RET_RST;
			mk_ret_q             <= `CIV_RET_RST;
		end else begin
			control_status_reg_q <= control_status_reg_d;
			enable_mask_reg_q    <= enable_mask_reg_d;
			pending_flag_reg_q   <= pending_flag_reg_d;
			if (mv_wr && mv_sel == `CIV_SEL_VPTR) begin
				vector_table_base_q <= mv_wdata[31:`CIV_BASE_LO];
			end
			// a take overwrites any value software left in a pointer
			if (take_nmi) begin
				nm_ret_q <= return_pc;
			end else if (mv_wr && mv_sel == `CIV_SEL_NMRET) begin
				nm_ret_q <= mv_wdata;
			end
			if (take_maskable) begin
				mk_ret_q <= return_pc;
			end else if (mv_wr && mv_sel == `CIV_SEL_MKRET) begin
				mk_ret_q <= mv_wdata;
			end
		end
	end

	// registered read path; set and clear ports read back zero
	always @(posedge clock) begin
		if (!rst_n) begin
			mv_rdata <= `CIV_RDATA_RST;
		end else begin
			case (mv_sel)
			`CIV_SEL_CTRL:  mv_rdata <= control_status_reg_q;
			`CIV_SEL_MASK:  mv_rdata <= {16'h0000, enable_mask_reg_q};
			`CIV_SEL_PEND:  mv_rdata <= {16'h0000, pending_flag_reg_q};
			`CIV_SEL_VPTR:  mv_rdata <= vector_table_pointer;
			`CIV_SEL_NMRET: mv_rdata <= nm_ret_q;
			`CIV_SEL_MKRET: mv_rdata <= mk_ret_q;
			default:        mv_rdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // civ_core

// file: rtl/civ_defs.vh
`ifndef CIV_DEFS_VH
`define CIV_DEFS_VH
// control register select codes for the move port
`define CIV_SEL_CTRL    3'h0
`define CIV_SEL_MASK    3'h1
`define CIV_SEL_PEND    3'h2
`define CIV_SEL_FSET    3'h3
`define CIV_SEL_FCLR    3'h4
`define CIV_SEL_VPTR    3'h5
`define CIV_SEL_NMRET   3'h6
`define CIV_SEL_MKRET   3'h7
// control/status field positions
`define CIV_GEN_BIT     0
`define CIV_SAVED_BIT   1
// enable register fields
`define CIV_RST_BIT     0
`define CIV_NMI_BIT     1
`define CIV_RSV_HI      3
`define CIV_RSV_LO      2
`define CIV_MASK_LO     4
// vector table pointer fields
`define CIV_NUM_LO      5
`define CIV_NUM_HI      9
`define CIV_BASE_LO     10
// reset values
`define CIV_CTRL_RST    32'h0000_0000
`define CIV_MASK_RST    16'h0001
`define CIV_PEND_RST    16'h0000
`define CIV_BASE_RST    22'h00_0000
`define CIV_RET_RST     32'h0000_0000
`define CIV_RDATA_RST   32'h0000_0000
// writable maskable flag lanes (bits 15..4)
`define CIV_MASKABLE    16'hFFF0
// lanes an incoming edge may set: maskable lanes plus nmi
`define CIV_EDGE_LANES  16'hFFF2
`endif

// file: rtl/civ_prio_enc.v
`timescale 1ns/1ns
// lowest-numbered set bit wins, zero when none set
module civ_prio_enc (
	// candidates
	input  wire [15:0] cand,
	// encoded winner
	output reg  [4:0]  num
);
	integer i;

	// scan downward so the lowest index is the last to win
	always @* begin
		num = 5'h00;
		for (i = 15; i >= 0; i = i - 1) begin
			if (cand[i]) begin
				num = i[4:0];
			end
		end
	end
endmodule // civ_prio_enc

// file: tb/civ_irq_src.sv
`timescale 1ns/1ns
// request sources: each line follows its fire bit one cycle later
module civ_irq_src (
	// clock and command
	input  wire        clock,
	input  wire [15:0] fire,
	// request lines
	output reg  [15:0] irq_lines
);
	initial irq_lines = 16'h0000;
	// lines stay low outside a fire request
	always @(posedge clock) begin
		irq_lines <= fire;
	end
endmodule // civ_irq_src

// file: tb/civ_checker.sv
`timescale 1ns/1ns
// watches the core's ports
module civ_checker (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// move port and events
	input wire logic        mv_wr,
	input wire logic [2:0]  mv_sel,
	input wire logic [31:0] mv_wdata,
	input wire logic [31:0] mv_rdata,
	input wire logic        take_maskable,
	input wire logic        ret_maskable,
	input wire logic [31:0] return_pc,
	// status
	input wire logic        maskable_req,
	input wire logic [4:0]  req_number,
	input wire logic [31:0] vector_addr,
	input wire logic [31:0] maskable_return_pointer
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_vec;
		vector_addr[9:0] == {req_number, 5'h00};
	endproperty
	a_vec: assert property (p_vec) else $error("vector field");
	property p_take;
		take_maskable && !mv_wr && mv_sel == 3'h0 ##1
		mv_sel == 3'h0 && !mv_wr && !take_maskable && !ret_maskable
		|=> !mv_rdata[0] && mv_rdata[1] == $past(mv_rdata[0]);
	endproperty
	a_take: assert property (p_take) else $error("enable save");
	property p_ret;
		ret_maskable && !take_maskable && !mv_wr && mv_sel == 3'h0 ##1
		mv_sel == 3'h0 && !mv_wr && !take_maskable
		|=> mv_rdata[0] == mv_rdata[1];
	endproperty
	a_ret: assert property (p_ret) else $error("enable restore");
	property p_irp;
		take_maskable |=> maskable_return_pointer == $past(return_pc);
	endproperty
	a_irp: assert property (p_irp) else $error("return pointer");
	property p_base;
		mv_wr && mv_sel == 3'h5
		|=> vector_addr[31:10] == $past(mv_wdata[31:10]);
	endproperty
	a_base: assert property (p_base) else $error("table base");
	property p_rst;
		$rose(rst_n) |-> vector_addr[31:10] == 22'h00_0000;
	endproperty
	a_rst: assert property (p_rst) else $error("base reset");
	property p_req;
		maskable_req |-> req_number >= 5'h04 && req_number <= 5'h0f;
	endproperty
	a_req: assert property (p_req) else $error("maskable number");
	property p_set;
		mv_wr && mv_sel == 3'h3 ##1 !mv_wr && !take_maskable
		##1 mv_sel == 3'h2 && !mv_wr
		|=> &(mv_rdata[15:4] | ~$past(mv_wdata[15:4], 3));
	endproperty
	a_set: assert property (p_set) else $error("flag set");
endmodule // civ_checker
bind civ_core civ_checker u_civ_checker (.clock(clock), .rst_n(rst_n),
	.mv_wr(mv_wr), .mv_sel(mv_sel), .mv_wdata(mv_wdata),
	.mv_rdata(mv_rdata), .take_maskable(take_maskable),
	.ret_maskable(ret_maskable), .return_pc(return_pc),
	.maskable_req(maskable_req), .req_number(req_number),
	.vector_addr(vector_addr),
	.maskable_return_pointer(maskable_return_pointer));

// file: tb/tb.sv
`timescale 1ns/1ns
module tb;
	reg         clock = 0, rst_n = 0, mv_wr = 0, take_maskable = 0;
	reg         take_nmi = 0, ret_maskable = 0, ret_nmi = 0;
	reg  [2:0]  mv_sel = 0;
	reg  [31:0] mv_wdata = 0, return_pc = 0, v;
	reg  [15:0] fire = 0;
	wire [15:0] irq_lines;
	wire [31:0] mv_rdata, vector_addr, nm_ret, mk_ret;
	wire        maskable_req;
	wire [4:0]  req_number;
	integer     n_errors = 0, num_checks = 0;
	civ_core u_civ_core (.clock(clock), .rst_n(rst_n),
		.irq_lines(irq_lines), .mv_wr(mv_wr), .mv_sel(mv_sel),
		.mv_wdata(mv_wdata), .mv_rdata(mv_rdata),
		.take_maskable(take_maskable), .take_nmi(take_nmi),
		.return_pc(return_pc), .ret_maskable(ret_maskable),
		.ret_nmi(ret_nmi), .maskable_req(maskable_req),
		.req_number(req_number), .vector_addr(vector_addr),
		.nonmaskable_return_pointer(nm_ret),
		.maskable_return_pointer(mk_ret));
	civ_irq_src u_civ_irq_src (.clock(clock), .fire(fire),
		.irq_lines(irq_lines));
	initial forever #5 clock = ~clock;
	task chk(input [8*8:1] nm, input [31:0] s, e); begin
		num_checks = num_checks + 1;
		if (s !== e) begin
			n_errors = n_errors + 1;
			$display("[FAIL] %0s expected %h seen %h", nm, e, s);
		end
	end endtask
	task wr(input [2:0] s, input [31:0] d); begin
		@(posedge clock) {mv_wr, mv_sel, mv_wdata} <= {1'b1, s, d};
		@(posedge clock) mv_wr <= 1'b0;
		#1;
	end endtask
	task rd(input [2:0] s); begin
		@(posedge clock) mv_sel <= s;
		repeat (2) @(posedge clock);
		#1 v = mv_rdata;
	end endtask
	task t_reset; begin
		rd(0); chk("ctrl", v, 0);
		rd(1); chk("enable", v, 1);
		rd(2); chk("pending", v, 0);
		rd(5); chk("pointer", v, 0);
	end endtask
	task t_vector; begin
		wr(1, 32'h0000_1232); wr(3, 32'h0000_bbc0); wr(5, 32'h0000_0800);
		chk("vector", vector_addr, 32'h0000_0920);
		chk("number", req_number, 9);
		chk("req_off", maskable_req, 0);
		rd(2); chk("pending", v, 32'h0000_bbc0);
		wr(0, 1); chk("req_on", maskable_req, 1);
	end endtask
	task t_take; begin
		@(posedge clock) {take_maskable, return_pc} <= {1'b1, 32'h1234};
		@(posedge clock) take_maskable <= 1'b0;
		#1 chk("next", req_number, 12);
		rd(0); chk("saved", v, 2);
		rd(7); chk("irp", v, 32'h1234);
		chk("mk_ret", mk_ret, 32'h1234);
		@(posedge clock) ret_maskable <= 1'b1;
		@(posedge clock) ret_maskable <= 1'b0;
		rd(0); chk("restore", v, 3);
		@(posedge clock) {take_maskable, mv_wr, mv_sel} <= 5'b11000;
		mv_wdata <= 0;
		@(posedge clock) {take_maskable, mv_wr} <= 2'b00;
		rd(0); chk("coincide", v, 0);
		chk("none", vector_addr, 32'h0000_0800);
	end endtask
	task t_nmi_irq; begin
		@(posedge clock) {take_nmi, return_pc} <= {1'b1, 32'h55};
		@(posedge clock) {take_nmi, ret_nmi} <= 2'b01;
		@(posedge clock) ret_nmi <= 1'b0;
		rd(6); chk("nrp", v, 32'h55);
		chk("nm_ret", nm_ret, 32'h55);
		rd(1); chk("gate", v, 32'h0000_1233);
		@(posedge clock) fire <= 16'h4000;
		repeat (6) @(posedge clock);
		fire <= 0;
		rd(2); chk("edge", v, 32'h0000_e9c0);
		wr(4, 32'h0000_ffff); rd(2); chk("clear", v, 0);
		chk("zero", req_number, 0);
		wr(3, 32'h0000_0050); rd(2); chk("set", v, 32'h0000_0050);
	end endtask
	task finish_test; begin
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	end endtask
	initial begin
		#20000 n_errors = n_errors + 1;
		finish_test;
	end
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		t_reset; t_vector; t_take; t_nmi_irq;
		finish_test;
	end
endmodule // tb
